// ---- rtl/ols_pkg.sv ----
// constants shared by the octal low-side driver logic
package ols_pkg;
  localparam int NCH = 8;
  localparam int NDIR = 2;
  localparam int PIN_W = 23;
  // ****************************************
  // pin vector layout
  // ****************************************
  localparam int P_SCK = 0;
  localparam int P_CS = 1;
  localparam int P_SDI = 2;
  localparam int P_XRST = 3;
  localparam int P_DIR = 4;
  localparam int P_UV = 6;
  localparam int P_OC = 7;
  localparam int P_OT = 13;
  localparam int P_CMP = 15;
  // select high, direct drives high, external reset low
  localparam logic [22:0] PIN_RST = 23'h000032;
  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] A_STAT = 4'h0;
  localparam logic [3:0] A_OVL = 4'h4;
  localparam logic [3:0] A_CFG = 4'h8;
  localparam int F_ON = 0;
  localparam int F_OVL = 8;
  localparam int F_FLT = 16;
  localparam int F_RST = 24;
  localparam int FILT_W = 4;
  localparam logic [3:0] CFG_RST = 4'h3;
  localparam int CNT_W = 3;
endpackage

// ---- rtl/ols_driver.sv ----
// serial control, protection and diagnostic logic of the octal driver
// Overview of operation
// R1 - while selected, shift serial input into 8-bit register on clock fall
// R2 - select release copies shift register into the channel latches
// R3 - copy only when clock count since select fall is nonzero multiple of 8
// R4 - controller changes select only while serial clock is low
// R5 - channels 1,2 on if direct input low or latch bit set
// R6 - channels 3 to 8 follow only their own latch bit
// R7 - internal reset is external reset or undervoltage
// R8 - one common reset gates all eight channels off
// R9 - overcurrent on channels 3 to 8 sets overload latch, switches off
// R10 - overtemperature on channels 1,2 sets overload latch, switches off
// R11 - channels 1,2 diagnostic is filtered and held in a fault latch
// R12 - fault latches of channels 1,2 clear while selected
// R13 - controller trusts the second status read after a fault
// R14 - channels 1,2 on: status high below threshold, low above
// R15 - channel off: status high above threshold, low below
// R16 - channels 3 to 8 status passes comparator straight through
// R17 - overcurrent on channels 3 to 8 leaves channel off, status low
// R18 - select fall loads eight status bits into shift register
// R19 - while selected, next shift bit appears on serial out at clock rise
// R20 - serial out driven only while selected, floats afterwards
// R21 - bit k is channel k, channel 8 bit shifted first both ways
// R22 - internal reset clears latches, shift register and overload latches
//
// Local design decisions: the Avalon-MM register port and the register offsets.
module ols_driver #(
  parameter int NCH = ols_pkg::NCH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic chip_select_low_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic external_reset_n_i,
  input wire logic undervoltage_i,
  input wire logic direct_drive1_low_i,
  input wire logic direct_drive2_low_i,
  input wire logic [5:0] overcurrent_i,
  input wire logic [1:0] overtemp_i,
  input wire logic [7:0] above_thr_i,
  output logic [7:0] ch_on_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [ols_pkg::PIN_W-1:0] pins;
  logic [ols_pkg::PIN_W-1:0] s1_r;
  logic [ols_pkg::PIN_W-1:0] s2_r;
  logic [ols_pkg::PIN_W-1:0] s3_r;
  logic [ols_pkg::PIN_W-1:0] pin_r;
  logic sck_q_r;
  logic cs_q_r;

  assign pins = {above_thr_i, overtemp_i, overcurrent_i, undervoltage_i,
                 direct_drive2_low_i, direct_drive1_low_i,
                 external_reset_n_i, sdi_i, chip_select_low_i, sck_i};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= ols_pkg::PIN_RST;
      s2_r <= ols_pkg::PIN_RST;
      s3_r <= ols_pkg::PIN_RST;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < ols_pkg::PIN_W; gi++) begin : g_pin
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_r[gi] <= ols_pkg::PIN_RST[gi];
        end else if (s2_r[gi] == s3_r[gi]) begin
          pin_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end else begin
      sck_q_r <= pin_r[ols_pkg::P_SCK];
      cs_q_r <= pin_r[ols_pkg::P_CS];
    end
  end

  logic cs_f;
  logic sdi_f;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic rst_int;
  logic [1:0] dir_low;
  logic [5:0] oc_f;
  logic [1:0] ot_f;
  logic [7:0] cmp_f;

  assign cs_f = pin_r[ols_pkg::P_CS];
  assign sdi_f = pin_r[ols_pkg::P_SDI];
  assign sck_rise = pin_r[ols_pkg::P_SCK] & ~sck_q_r;
  assign sck_fall = ~pin_r[ols_pkg::P_SCK] & sck_q_r;
  assign cs_rise = cs_f & ~cs_q_r;
  assign cs_fall = ~cs_f & cs_q_r;
  assign dir_low = pin_r[ols_pkg::P_DIR +: 2];
  assign oc_f = pin_r[ols_pkg::P_OC +: 6];
  assign ot_f = pin_r[ols_pkg::P_OT +: 2];
  assign cmp_f = pin_r[ols_pkg::P_CMP +: 8];
  // either source alone holds the core in reset
  assign rst_int = ~pin_r[ols_pkg::P_XRST] | pin_r[ols_pkg::P_UV]; // R7

  // ****************************************
  // register bus slave
  // ****************************************
  logic wait_r;
  logic [31:0] rdata_r;
  logic [ols_pkg::FILT_W-1:0] cfg_r;
  logic [7:0] ovl_r;
  logic [1:0] fault_v;
  logic wr_acc;

  // every access waits exactly one cycle
  assign wr_acc = avs_write_i & ~wait_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i && wait_r) begin
      rdata_r <= 32'h0000_0000;
      case (avs_address_i)
        ols_pkg::A_STAT: begin
          rdata_r[ols_pkg::F_ON +: 8] <= ch_on_o;
          rdata_r[ols_pkg::F_OVL +: 8] <= ovl_r;
          rdata_r[ols_pkg::F_FLT +: 2] <= fault_v;
          rdata_r[ols_pkg::F_RST] <= rst_int;
        end
        ols_pkg::A_OVL: begin
          rdata_r[7:0] <= ovl_r;
        end
        ols_pkg::A_CFG: begin
          rdata_r[ols_pkg::FILT_W-1:0] <= cfg_r;
        end
        default: begin
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= ols_pkg::CFG_RST;
    end else if (wr_acc && avs_address_i == ols_pkg::A_CFG) begin
      cfg_r <= avs_writedata_i[ols_pkg::FILT_W-1:0];
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  // ****************************************
  // overload latches
  // ****************************************
  logic [7:0] ovl_set;
  logic [7:0] ovl_clr;

  assign ovl_set = {oc_f & ch_on_o[7:2], ot_f}; // R9 R10 R17
  assign ovl_clr = (wr_acc && avs_address_i == ols_pkg::A_OVL) ?
                   avs_writedata_i[7:0] : 8'h00;

  // a new overload beats a software clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovl_r <= 8'h00;
    end else if (rst_int) begin
      ovl_r <= 8'h00; // R22
    end else begin
      ovl_r <= (ovl_r & ~ovl_clr) | ovl_set;
    end
  end

  // ****************************************
  // diagnostic filter and fault latches
  // ****************************************
  generate
    for (gi = 0; gi < ols_pkg::NDIR; gi++) begin : g_flt
      logic [ols_pkg::FILT_W-1:0] fc_r;
      logic fs_r;
      logic flt_r;
      logic raw;
      assign raw = ch_on_o[gi] ? ~cmp_f[gi] : cmp_f[gi]; // R14 R15
      // short glitches on the comparator never reach the latch
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          fc_r <= '0;
          fs_r <= 1'b1;
        end else if (rst_int) begin
          // held in reset, so synchroniser start-up is never a fault
          fc_r <= '0;
          fs_r <= 1'b1;
        end else if (raw == fs_r) begin
          fc_r <= '0;
        end else if (fc_r >= cfg_r) begin
          fc_r <= '0;
          fs_r <= raw; // R11
        end else begin
          fc_r <= fc_r + 1'b1;
        end
      end
      // clear wins while selected, so a fault that has gone still shows at the next read
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          flt_r <= 1'b0;
        end else if (rst_int || !cs_f) begin
          flt_r <= 1'b0; // R12
        end else if (!fs_r) begin
          flt_r <= 1'b1; // R11
        end
      end
      assign fault_v[gi] = flt_r;
    end
  endgenerate

  logic [7:0] stat;
  assign stat = {cmp_f[7:2], ~fault_v}; // R16 R21

  // ****************************************
  // serial shift register and latch transfer
  // ****************************************
  localparam int CNT_W_L = ols_pkg::CNT_W;
  logic [7:0] sr_r;
  logic [CNT_W_L-1:0] cnt_r;
  logic seen_r;
  logic [7:0] latch_r;
  logic xfer_ok;

  // count wraps every eight clocks, so zero with seen means a multiple
  assign xfer_ok = seen_r && (cnt_r == '0); // R3

  // relies on select moving only with the serial clock low
  always_ff @(posedge clk_i or negedge rst_n_i) begin // R4
    if (!rst_n_i) begin
      sr_r <= 8'h00;
      cnt_r <= '0;
      seen_r <= 1'b0;
    end else if (rst_int) begin
      sr_r <= 8'h00; // R22
      cnt_r <= '0;
      seen_r <= 1'b0;
    end else if (cs_fall) begin
      sr_r <= stat; // R18
      cnt_r <= '0;
      seen_r <= 1'b0;
    end else if (!cs_f && sck_fall) begin
      sr_r <= {sr_r[6:0], sdi_f}; // R1 R21
      cnt_r <= cnt_r + 1'b1;
      seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_r <= 8'h00;
    end else if (rst_int) begin
      latch_r <= 8'h00; // R22
    end else if (cs_rise && xfer_ok) begin
      latch_r <= sr_r; // R2 R3
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  logic sdo_r;
  logic sdo_oe_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_oe_r <= ~cs_f; // R20
      if (cs_fall) begin
        sdo_r <= stat[7];
      end else if (sck_rise && !cs_f) begin
        sdo_r <= sr_r[7]; // R19
      end
    end
  end

  assign sdo_o = sdo_r;
  assign sdo_oe_o = sdo_oe_r;

  // ****************************************
  // channel drive
  // ****************************************
  logic [7:0] on_nxt;
  logic [7:0] on_r;

  always_comb begin
    on_nxt = latch_r; // R6
    on_nxt[1:0] = latch_r[1:0] | ~dir_low; // R5
    on_nxt = on_nxt & ~ovl_r & {8{~rst_int}}; // R8 R9 R10
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_r <= 8'h00;
    end else begin
      on_r <= on_nxt;
    end
  end

  assign ch_on_o = on_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_shift_in: assert property ( // R1
    sck_fall && !cs_f && !cs_fall && !rst_int
    |=> sr_r == {$past(sr_r[6:0]), $past(sdi_f)})
    else $error("shift register did not take serial input");
  chk_latch_xfer: assert property ( // R2
    cs_rise && xfer_ok && !rst_int |=> latch_r == $past(sr_r))
    else $error("latch transfer missing on select release");
  chk_xfer_filter: assert property ( // R3
    cs_rise && !xfer_ok && !rst_int |=> $stable(latch_r))
    else $error("latch changed after incomplete frame");
  chk_direct_on: assert property ( // R5
    !dir_low[0] && !ovl_r[0] && !rst_int |=> ch_on_o[0])
    else $error("direct drive did not switch channel 1 on");
  chk_latch_only: assert property ( // R6
    1'b1 |=> ch_on_o[7] == $past(latch_r[7] & ~ovl_r[7] & ~rst_int))
    else $error("channel 8 not following its latch bit");
  chk_reset_off: assert property ( // R8
    rst_int |=> ch_on_o == 8'h00)
    else $error("channel on during internal reset");
  chk_ovc_trip: assert property ( // R9
    oc_f[5] && ch_on_o[7] && !rst_int |=> ovl_r[7] ##1 !ch_on_o[7])
    else $error("overcurrent did not trip channel 8");
  chk_fault_clr: assert property ( // R12
    !cs_f |=> fault_v == 2'b00)
    else $error("fault latch not cleared while selected");
  chk_status_load: assert property ( // R18
    cs_fall && !rst_int |=> sr_r == $past(stat))
    else $error("status not loaded at select fall");
  chk_sdo_next: assert property ( // R19
    sck_rise && !cs_f && !cs_fall |=> sdo_o == $past(sr_r[7]))
    else $error("serial out did not present next bit");
  chk_sdo_float: assert property ( // R20
    cs_f [*2] |=> !sdo_oe_o)
    else $error("serial out driven while deselected");
endmodule

// ---- tb/ols_spi_host.sv ----
// serial bus master model standing in for the host controller
module ols_spi_host (
  output logic sck_o,
  output logic cs_low_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // frame engine
  // ****************************************
  // sck stands still low between frames; half period 100 ns
  initial begin
    sck_o = 1'b0;
    cs_low_o = 1'b1;
    sdi_o = 1'b1;
  end
  task automatic frame(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    int i;
    // stay off the system clock edge that the bench calls from
    #3;
    cs_low_o = 1'b0;
    #300;
    for (i = 0; i < n; i++) begin
      sdi_o = tx[7 - (i % 8)];
      sck_o = 1'b1;
      #100;
      sck_o = 1'b0;
      #100;
      // sampled late in the low phase, after the slave had its rise
      if (i < 8) rx[7 - i] = sdo_i;
    end
    cs_low_o = 1'b1;
    // released data line shows no stale level
    sdi_o = ~sdi_o;
    #400;
  endtask
endmodule

// ---- tb/test_ols_driver.sv ----
// self-checking bench of the octal low-side driver
`define CHK(a, b) begin cmp_count++; \
  if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ols_driver;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sck, csl, sdi, sdo, sdo_oe, sdo_w;
  logic xrst_n = 1'b1;
  logic uv = 1'b0;
  logic dd1_low = 1'b1;
  logic dd2_low = 1'b1;
  logic [5:0] oc = 6'h00;
  logic [1:0] ot = 2'h0;
  logic [7:0] above = 8'hFF;
  logic [7:0] ch_on, rx;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic wait_rq;
  int miscompares = 0;
  int cmp_count = 0;
  // nobody pulls the data line, so a float must never read as data
  assign sdo_w = sdo_oe ? sdo : 1'bz;
  ols_driver uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck),
    .chip_select_low_i(csl), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .external_reset_n_i(xrst_n), .undervoltage_i(uv),
    .direct_drive1_low_i(dd1_low), .direct_drive2_low_i(dd2_low),
    .overcurrent_i(oc), .overtemp_i(ot), .above_thr_i(above),
    .ch_on_o(ch_on), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_rq));
  ols_spi_host host (.sck_o(sck), .cs_low_o(csl), .sdi_o(sdi),
    .sdo_i(sdo_w));
  // ****************************************
  // helpers
  // ****************************************
  initial forever #12.5 clk_i = ~clk_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rv);
    @(posedge clk_i);
    addr <= a;
    wdata <= wd;
    rd <= ~w;
    wr <= w;
    // only the watchdog ends a stalled wait
    do begin
      @(posedge clk_i);
    end while (wait_rq !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic send(input logic [7:0] tx, input int n);
    host.frame(tx, n, rx);
    tick(12);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    bus(1'b0, ols_pkg::A_STAT, 32'h0, d);
    `CHK(d[15:0], 16'h0000)
    `CHK(ch_on, 8'h00)
    bus(1'b0, ols_pkg::A_CFG, 32'h0, d);
    `CHK(d[3:0], ols_pkg::CFG_RST)
    bus(1'b1, ols_pkg::A_CFG, 32'h5, d);
    bus(1'b0, ols_pkg::A_CFG, 32'h0, d);
    `CHK(d[3:0], 4'h5)
    bus(1'b1, ols_pkg::A_CFG, 32'h3, d);
    bus(1'b0, 4'hC, 32'h0, d);
    `CHK(d, 32'h00000000)
  endtask
  task automatic t_serial();
    @(posedge clk_i) above <= 8'h5A;
    tick(20);
    host.frame(8'hA4, 8, rx);
    `CHK(rx, 8'h5A)
    tick(12);
    `CHK(ch_on, 8'hA4)
    `CHK(sdo_oe, 1'b0)
    send(8'h3C, 7);
    `CHK(ch_on, 8'hA4)
    send(8'h0F, 16);
    `CHK(ch_on, 8'h0F)
  endtask
  task automatic t_direct();
    send(8'hF0, 8);
    @(posedge clk_i) dd1_low <= 1'b0;
    tick(10);
    `CHK(ch_on, 8'hF1)
    @(posedge clk_i) begin
      dd1_low <= 1'b1;
      dd2_low <= 1'b0;
    end
    tick(10);
    `CHK(ch_on, 8'hF2)
    @(posedge clk_i) dd2_low <= 1'b1;
  endtask
  task automatic t_overload();
    @(posedge clk_i) oc <= 6'h24;
    tick(8);
    `CHK(ch_on, 8'h60)
    @(posedge clk_i) oc <= 6'h00;
    bus(1'b0, ols_pkg::A_STAT, 32'h0, d);
    `CHK(d[15:8], 8'h90)
    host.frame(8'hF0, 8, rx);
    `CHK(rx[7:2], above[7:2])
    tick(12);
    `CHK(ch_on, 8'h60)
    bus(1'b1, ols_pkg::A_OVL, 32'h90, d);
    tick(4);
    `CHK(ch_on, 8'hF0)
    @(posedge clk_i) begin
      dd1_low <= 1'b0;
      ot <= 2'h1;
    end
    tick(8);
    `CHK(ch_on[0], 1'b0)
    @(posedge clk_i) ot <= 2'h0;
    bus(1'b0, ols_pkg::A_STAT, 32'h0, d);
    `CHK(d[8], 1'b1)
    bus(1'b1, ols_pkg::A_OVL, 32'h1, d);
  endtask
  task automatic t_fault();
    @(posedge clk_i) above <= 8'h01;
    tick(20);
    host.frame(8'h00, 8, rx);
    `CHK(rx[0], 1'b0)
    @(posedge clk_i) above <= 8'h00;
    tick(20);
    host.frame(8'h00, 8, rx);
    `CHK(rx[0], 1'b0)
    bus(1'b0, ols_pkg::A_STAT, 32'h0, d);
    `CHK(d[16], 1'b0)
    host.frame(8'h00, 8, rx);
    `CHK(rx[0], 1'b1)
    @(posedge clk_i) dd1_low <= 1'b1;
  endtask
  task automatic t_reset_src();
    int i;
    for (i = 0; i < 2; i++) begin
      send(8'hFF, 8);
      `CHK(ch_on, 8'hFF)
      @(posedge clk_i) begin
        xrst_n <= (i != 0);
        uv <= (i == 1);
      end
      tick(8);
      bus(1'b0, ols_pkg::A_STAT, 32'h0, d);
      `CHK(d[24], 1'b1)
      `CHK(ch_on, 8'h00)
      @(posedge clk_i) begin
        xrst_n <= 1'b1;
        uv <= 1'b0;
      end
      tick(10);
      `CHK(ch_on, 8'h00)
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(8);
    t_regs();
    t_serial();
    t_direct();
    t_overload();
    t_fault();
    t_reset_src();
    report_and_stop();
  end
  initial begin
    #1ms;
    miscompares++;
    report_and_stop();
  end
endmodule
